// ---- rtl/pmic_two_wire_pkg.sv ----
// constants, state encodings and register layout of the two-wire slave ports
//
// How it works
// R1: main port answers write address 0x90 and read address 0x91, both configurable.
// R2: serial clock up to 400 kHz; logic follows any host rate below it.
// R3: data line only pulls low for bits and acks; clock line never driven.
// R4: high-speed clock up to 1.7 MHz with identical protocol behaviour.
// R5: device is slave only; never makes start, stop or clock.
// R6: register address MSB picks page; page control locations stay untouched.
// R7: bytes of eight bits, MSB first; data changes while clock low.
// R8: start is data falling with clock high; stop is data rising.
// R9: while enabled, own address is acked by pulling data low.
// R10: write is start, address, register address, data, stop; each byte acked.
// R11: read first writes register address, then restart with read address.
// R12: host repeats the same slave address after a repeated start.
// R13: master ack after a read byte advances pointer and sends next register.
// R14: reading a missing register returns zero.
// R15: consecutive write bytes are stored, pointer advanced, each acked.
// R16: alternating mode takes address, data, address, data in one message.
// R17: start or stop inside a message drops it and returns to idle; the code sends a start straight to the address phase instead.
// R18: alternate port answers 0x92 and 0x93, same protocol otherwise.
// R19: alternate port enabled by pin select; then clock pin settings ignored.
// R20: matching access on alternate port raises interrupt and optional wake-up.
// R21: host masks alternate access interrupt while that port is in use.
// R22: host supplies serial clock for every transfer.
// R23: unmatched address leaves data released until next start.
package pmic_two_wire_pkg;

  // ------------------------------------------------------------
  // clock and bus rates
  // ------------------------------------------------------------
  localparam int REF_CLK_HZ = 50_000_000;
  localparam int STD_MAX_HZ = 400_000;
  localparam int HS_MAX_HZ = 1_700_000;
  // shortest serial half period in reference cycles, rounded down
  localparam int STD_HALF_CYCLES = REF_CLK_HZ / (2 * STD_MAX_HZ);
  localparam int HS_HALF_CYCLES = REF_CLK_HZ / (2 * HS_MAX_HZ);
  // reference cycles from a bank fetch request to its answer
  localparam int FETCH_CYCLES = 4;

  // ------------------------------------------------------------
  // software register map
  // ------------------------------------------------------------
  localparam logic [2:0] REG_MAIN_WR_ADDR = 3'h0;
  localparam logic [2:0] REG_MAIN_RD_ADDR = 3'h1;
  localparam logic [2:0] REG_ALT_WR_ADDR = 3'h2;
  localparam logic [2:0] REG_ALT_RD_ADDR = 3'h3;
  localparam logic [2:0] REG_CTRL = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;

  localparam logic [7:0] MAIN_WR_ADDR_RST = 8'h90;
  localparam logic [7:0] MAIN_RD_ADDR_RST = 8'h91;
  localparam logic [7:0] ALT_WR_ADDR_RST = 8'h92;
  localparam logic [7:0] ALT_RD_ADDR_RST = 8'h93;
  localparam logic [7:0] CTRL_RST = 8'h01;

  // control register fields
  localparam int CTRL_MAIN_EN = 0;
  localparam int CTRL_ALT_WRITE = 1;
  localparam int CTRL_ALT_SEL = 2;
  localparam int CTRL_ALT_WAKE = 3;
  localparam int CTRL_ALT_IRQ = 4;
  localparam int CTRL_CLK_FUNC = 5;
  localparam int CTRL_CLK_MODE = 6;

  // status register fields
  localparam int STAT_MAIN_BUSY = 0;
  localparam int STAT_ALT_BUSY = 1;

  // page control location, low seven bits of the register address
  localparam logic [6:0] PAGE_CTRL_INDEX = 7'h00;

  // ------------------------------------------------------------
  // protocol engine states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    IDLE,
    SLV_ADDR,
    REG_ADDR,
    WR_DATA,
    ACK_OUT,
    TX_DATA,
    RX_ACK,
    IGNORE
  } eng_state_e;

endpackage

// ---- rtl/pmic_two_wire_slave_port.sv ----
// two-wire slave engine and the port block holding main and alternate ports
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// protocol engine, one per serial port
// ------------------------------------------------------------
module two_wire_engine (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic en,
  input wire logic altWrite,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] rdAddr,
  input wire logic clkLine,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataDriveN,
  output logic reqValid,
  output logic reqWe,
  output logic [7:0] reqAddr,
  output logic [7:0] reqData,
  input wire logic grant,
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  output logic access,
  output logic busy
);
  import pmic_two_wire_pkg::*;

  typedef struct packed {
    logic clkS1;
    logic clkS2;
    logic clkP;
    logic datS1;
    logic datS2;
    logic datP;
    eng_state_e st;
    eng_state_e after;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [7:0] rdByte;
    logic driveN;
    logic addrPhase;
    logic masterAck;
    logic reqValid;
    logic reqWe;
    logic [7:0] reqAddr;
    logic [7:0] reqData;
    logic access;
    logic busy;
  } eng_s;

  eng_s st_r;
  eng_s st_nxt;
  logic rise;
  logic fall;
  logic startC;
  logic stopC;

  // edges from the second synchroniser stage and its follower only
  assign rise = st_r.clkS2 & ~st_r.clkP;
  assign fall = ~st_r.clkS2 & st_r.clkP;
  assign startC = st_r.clkS2 & st_r.clkP & st_r.datP & ~st_r.datS2; // R8
  assign stopC = st_r.clkS2 & st_r.clkP & ~st_r.datP & st_r.datS2; // R8

  // next state; the serial clock is only ever sampled, never driven
  always_comb begin
    st_nxt = st_r;
    st_nxt.clkS1 = clkLine; // R22
    st_nxt.clkS2 = st_r.clkS1; // R2
    st_nxt.clkP = st_r.clkS2;
    st_nxt.datS1 = dataIn;
    st_nxt.datS2 = st_r.datS1;
    st_nxt.datP = st_r.datS2;
    st_nxt.access = 1'b0;
    if (st_r.reqValid && grant) begin
      st_nxt.reqValid = 1'b0;
    end
    if (rdValid) begin
      st_nxt.rdByte = rdData;
    end
    if (!en) begin
      st_nxt.st = IDLE;
      st_nxt.driveN = 1'b1;
    end else if (startC) begin
      // restart or abort: any message in flight is dropped
      st_nxt.st = SLV_ADDR; // R17
      st_nxt.cnt = 4'h0;
      st_nxt.driveN = 1'b1;
    end else if (stopC) begin
      st_nxt.st = IDLE; // R17
      st_nxt.driveN = 1'b1;
    end else begin
      case (st_r.st)
        SLV_ADDR, REG_ADDR, WR_DATA: begin
          if (rise) begin
            st_nxt.shift = {st_r.shift[6:0], st_r.datS2}; // R7
            st_nxt.cnt = st_r.cnt + 4'h1;
          end
          if (fall && st_r.cnt == 4'h8) begin
            st_nxt.cnt = 4'h0;
            st_nxt.driveN = 1'b0; // R10
            st_nxt.st = ACK_OUT;
            case (st_r.st)
              SLV_ADDR: begin
                if (st_r.shift == wrAddr) begin
                  st_nxt.after = REG_ADDR; // R9
                  st_nxt.access = 1'b1;
                end else if (st_r.shift == rdAddr) begin
                  // fetch now so the first bit is ready at the ack's end
                  st_nxt.after = TX_DATA; // R11
                  st_nxt.access = 1'b1;
                  st_nxt.reqValid = 1'b1;
                  st_nxt.reqWe = 1'b0;
                  st_nxt.reqAddr = st_r.ptr;
                end else begin
                  st_nxt.driveN = 1'b1; // R23
                  st_nxt.st = IGNORE;
                end
              end
              REG_ADDR: begin
                st_nxt.ptr = st_r.shift; // R6
                st_nxt.addrPhase = 1'b0;
                st_nxt.after = WR_DATA;
              end
              default: begin
                st_nxt.after = WR_DATA;
                if (altWrite && st_r.addrPhase) begin
                  st_nxt.ptr = st_r.shift; // R16
                  st_nxt.addrPhase = 1'b0;
                end else begin
                  st_nxt.reqValid = 1'b1; // R15
                  st_nxt.reqWe = 1'b1;
                  st_nxt.reqAddr = st_r.ptr;
                  st_nxt.reqData = st_r.shift;
                  if (altWrite) begin
                    st_nxt.addrPhase = 1'b1; // R16
                  end else begin
                    st_nxt.ptr = st_r.ptr + 8'h01; // R15
                  end
                end
              end
            endcase
          end
        end
        ACK_OUT: begin
          if (fall) begin
            st_nxt.cnt = 4'h0;
            st_nxt.st = st_r.after;
            if (st_r.after == TX_DATA) begin
              st_nxt.shift = st_r.rdByte;
              st_nxt.driveN = st_r.rdByte[7]; // R7
            end else begin
              st_nxt.driveN = 1'b1;
            end
          end
        end
        TX_DATA: begin
          if (rise) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
          end
          if (fall) begin
            if (st_r.cnt == 4'h8) begin
              // release for the master's ack and prefetch the next register
              st_nxt.driveN = 1'b1;
              st_nxt.st = RX_ACK;
              st_nxt.cnt = 4'h0;
              st_nxt.ptr = st_r.ptr + 8'h01; // R13
              st_nxt.reqValid = 1'b1;
              st_nxt.reqWe = 1'b0;
              st_nxt.reqAddr = st_r.ptr + 8'h01;
            end else begin
              st_nxt.shift = {st_r.shift[6:0], 1'b0};
              st_nxt.driveN = st_r.shift[6]; // R7
            end
          end
        end
        RX_ACK: begin
          if (rise) begin
            st_nxt.masterAck = ~st_r.datS2;
          end
          if (fall) begin
            if (st_r.masterAck) begin
              st_nxt.shift = st_r.rdByte; // R13
              st_nxt.driveN = st_r.rdByte[7];
              st_nxt.st = TX_DATA;
            end else begin
              st_nxt.st = IGNORE; // R11
            end
          end
        end
        IDLE, IGNORE: begin
          st_nxt.driveN = 1'b1;
        end
        default: begin
          st_nxt.st = IDLE;
          st_nxt.driveN = 1'b1;
        end
      endcase
    end
    st_nxt.busy = (st_nxt.st != IDLE);
  end

  // state register; released line and idle bus after reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.clkS1 <= 1'b1;
      st_r.clkS2 <= 1'b1;
      st_r.clkP <= 1'b1;
      st_r.datS1 <= 1'b1;
      st_r.datS2 <= 1'b1;
      st_r.datP <= 1'b1;
      st_r.st <= IDLE;
      st_r.after <= IDLE;
      st_r.driveN <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // open-drain pin: value is always low, only the enable moves (R3, R5)
  assign dataOut = 1'b0; // R5
  assign dataDriveN = st_r.driveN; // R3
  assign reqValid = st_r.reqValid;
  assign reqWe = st_r.reqWe;
  assign reqAddr = st_r.reqAddr;
  assign reqData = st_r.reqData;
  assign access = st_r.access;
  assign busy = st_r.busy;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence addrDone;
    en && !startC && !stopC && fall && st_r.st == SLV_ADDR && st_r.cnt == 4'h8;
  endsequence
  sequence dataDone;
    en && !startC && !stopC && fall && st_r.st == WR_DATA && st_r.cnt == 4'h8;
  endsequence
  sequence masterAcked;
    en && !startC && !stopC && fall && st_r.st == RX_ACK && st_r.masterAck;
  endsequence

  idle_released_a: assert property (st_r.st == IDLE |-> st_r.driveN) // R17
    else $error("line driven while idle");
  stop_to_idle_a: assert property (en && stopC && !startC |=> st_r.st == IDLE && st_r.driveN) // R17
    else $error("stop did not return to idle");
  start_to_addr_a: assert property (en && startC |=> st_r.st == SLV_ADDR && st_r.cnt == 4'h0) // R8
    else $error("start did not open address phase");
  ack_on_match_a: assert property (addrDone ##0 (st_r.shift == wrAddr) |=> !st_r.driveN ##1 st_r.access == 1'b0) // R9
    else $error("own address not acknowledged");
  ignore_mismatch_a: assert property (
    addrDone ##0 (st_r.shift != wrAddr && st_r.shift != rdAddr) |=> st_r.driveN && st_r.st == IGNORE) // R23
    else $error("foreign address not ignored");
  page_write_a: assert property (dataDone ##0 !altWrite |=> st_r.ptr == $past(st_r.ptr) + 8'h01 && st_r.reqWe) // R15
    else $error("pointer not advanced on write");
  alt_addr_a: assert property (dataDone ##0 (altWrite && st_r.addrPhase) |=> st_r.ptr == $past(st_r.shift)) // R16
    else $error("alternating address not taken");
  drive_on_low_a: assert property ($fell(st_r.driveN) |-> !st_r.clkS2 || !st_r.clkP) // R7
    else $error("data pulled low while clock high");
  read_next_a: assert property (masterAcked |=> st_r.st == TX_DATA && st_r.driveN == st_r.shift[7]) // R13
    else $error("next read byte not started");
endmodule

// ------------------------------------------------------------
// port block: software registers, two engines, register bank access
// ------------------------------------------------------------
module pmic_two_wire_slave_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic serialClockLine,
  input wire logic mainDataIn,
  output logic mainDataOut,
  output logic mainDataDriveN,
  input wire logic altClockLine,
  input wire logic altDataIn,
  output logic altDataOut,
  output logic altDataDriveN,
  output logic [7:0] bankAddr,
  output logic [7:0] bankWdata,
  output logic bankWe,
  output logic bankRe,
  input wire logic [7:0] bankRdata,
  input wire logic bankHit,
  output logic interruptRequestOut,
  output logic altWakeupOut,
  output logic altClockPinFunctionOut,
  output logic altClockPinModeOut
);
  import pmic_two_wire_pkg::*;

  typedef struct packed {
    logic [7:0] mainWr;
    logic [7:0] mainRd;
    logic [7:0] altWr;
    logic [7:0] altRd;
    logic [7:0] ctrl;
    logic [7:0] regRdata;
    logic [7:0] bankAddr;
    logic [7:0] bankWdata;
    logic bankWe;
    logic bankRe;
    logic stage1;
    logic src1;
    logic zero1;
    logic stage2;
    logic src2;
    logic zero2;
    logic mainRdValid;
    logic altRdValid;
    logic [7:0] rdData;
    logic irq;
    logic wake;
    logic clkFunc;
    logic clkMode;
  } port_s;

  port_s st_r;
  port_s st_nxt;
  logic mainReq, mainWe, mainAccess, mainBusy;
  logic altReq, altWe, altAccess, altBusy;
  logic [7:0] mainAddr, mainData, altAddr, altData;
  logic grantMain, grantAlt;
  logic altEnable;
  logic reqWe;
  logic [7:0] reqAddr;
  logic [7:0] reqData;

  assign altEnable = st_r.ctrl[CTRL_ALT_SEL]; // R19

  // main power-manager port, addresses from software (R1)
  two_wire_engine mainPort (
    .ref_clk(ref_clk),
    .rst(rst),
    .en(st_r.ctrl[CTRL_MAIN_EN]),
    .altWrite(st_r.ctrl[CTRL_ALT_WRITE]),
    .wrAddr(st_r.mainWr),
    .rdAddr(st_r.mainRd),
    .clkLine(serialClockLine),
    .dataIn(mainDataIn),
    .dataOut(mainDataOut),
    .dataDriveN(mainDataDriveN),
    .reqValid(mainReq),
    .reqWe(mainWe),
    .reqAddr(mainAddr),
    .reqData(mainData),
    .grant(grantMain),
    .rdValid(st_r.mainRdValid),
    .rdData(st_r.rdData),
    .access(mainAccess),
    .busy(mainBusy)
  );

  // alternate fast port, same engine with its own addresses (R18, R4)
  two_wire_engine altPort (
    .ref_clk(ref_clk),
    .rst(rst),
    .en(altEnable),
    .altWrite(st_r.ctrl[CTRL_ALT_WRITE]),
    .wrAddr(st_r.altWr),
    .rdAddr(st_r.altRd),
    .clkLine(altClockLine), // R4
    .dataIn(altDataIn),
    .dataOut(altDataOut),
    .dataDriveN(altDataDriveN),
    .reqValid(altReq),
    .reqWe(altWe),
    .reqAddr(altAddr),
    .reqData(altData),
    .grant(grantAlt),
    .rdValid(st_r.altRdValid),
    .rdData(st_r.rdData),
    .access(altAccess),
    .busy(altBusy)
  );

  // fixed priority to the main port; a loser simply waits a cycle
  assign grantMain = mainReq;
  assign grantAlt = altReq & ~mainReq;
  assign reqWe = grantMain ? mainWe : altWe;
  assign reqAddr = grantMain ? mainAddr : altAddr;
  assign reqData = grantMain ? mainData : altData;

  // next state of registers, bank strobes and event outputs
  always_comb begin
    st_nxt = st_r;
    st_nxt.regRdata = 8'h00;
    st_nxt.bankWe = 1'b0;
    st_nxt.bankRe = 1'b0;
    st_nxt.stage1 = 1'b0;
    st_nxt.stage2 = st_r.stage1;
    st_nxt.src2 = st_r.src1;
    st_nxt.zero2 = st_r.zero1;
    st_nxt.mainRdValid = 1'b0;
    st_nxt.altRdValid = 1'b0;
    // software writes
    if (regWr) begin
      case (regAddr)
        REG_MAIN_WR_ADDR: st_nxt.mainWr = regWdata; // R1
        REG_MAIN_RD_ADDR: st_nxt.mainRd = regWdata; // R1
        REG_ALT_WR_ADDR: st_nxt.altWr = regWdata; // R18
        REG_ALT_RD_ADDR: st_nxt.altRd = regWdata; // R18
        REG_CTRL: st_nxt.ctrl = regWdata;
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    // software reads, unmapped offsets answer zero
    if (regRd) begin
      case (regAddr)
        REG_MAIN_WR_ADDR: st_nxt.regRdata = st_r.mainWr;
        REG_MAIN_RD_ADDR: st_nxt.regRdata = st_r.mainRd;
        REG_ALT_WR_ADDR: st_nxt.regRdata = st_r.altWr;
        REG_ALT_RD_ADDR: st_nxt.regRdata = st_r.altRd;
        REG_CTRL: st_nxt.regRdata = st_r.ctrl;
        REG_STATUS: begin
          st_nxt.regRdata[STAT_MAIN_BUSY] = mainBusy;
          st_nxt.regRdata[STAT_ALT_BUSY] = altBusy;
        end
        default: st_nxt.regRdata = 8'h00;
      endcase
    end
    // page control locations are neither written nor read here (R6)
    if (grantMain || grantAlt) begin
      if (reqAddr[6:0] == PAGE_CTRL_INDEX) begin
        st_nxt.stage1 = ~reqWe; // R6
        st_nxt.zero1 = 1'b1;
        st_nxt.src1 = grantAlt;
      end else begin
        st_nxt.bankAddr = reqAddr; // R6
        st_nxt.bankWdata = reqData;
        st_nxt.bankWe = reqWe;
        st_nxt.bankRe = ~reqWe;
        st_nxt.stage1 = ~reqWe;
        st_nxt.zero1 = 1'b0;
        st_nxt.src1 = grantAlt;
      end
    end
    // bank answers the cycle after its strobe; a miss reads as zero
    if (st_r.stage2) begin
      st_nxt.rdData = (st_r.zero2 || !bankHit) ? 8'h00 : bankRdata; // R14
      st_nxt.mainRdValid = ~st_r.src2;
      st_nxt.altRdValid = st_r.src2;
    end
    // access events of the alternate port; software masks them (R21)
    st_nxt.irq = altAccess & st_r.ctrl[CTRL_ALT_IRQ]; // R20
    st_nxt.wake = altAccess & st_r.ctrl[CTRL_ALT_WAKE]; // R20
    // clock pin settings lose effect while the alternate port owns it
    st_nxt.clkFunc = altEnable ? 1'b0 : st_r.ctrl[CTRL_CLK_FUNC]; // R19
    st_nxt.clkMode = altEnable ? 1'b0 : st_r.ctrl[CTRL_CLK_MODE]; // R19
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.mainWr <= MAIN_WR_ADDR_RST;
      st_r.mainRd <= MAIN_RD_ADDR_RST;
      st_r.altWr <= ALT_WR_ADDR_RST;
      st_r.altRd <= ALT_RD_ADDR_RST;
      st_r.ctrl <= CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdata = st_r.regRdata;
  assign bankAddr = st_r.bankAddr;
  assign bankWdata = st_r.bankWdata;
  assign bankWe = st_r.bankWe;
  assign bankRe = st_r.bankRe;
  assign interruptRequestOut = st_r.irq;
  assign altWakeupOut = st_r.wake;
  assign altClockPinFunctionOut = st_r.clkFunc;
  assign altClockPinModeOut = st_r.clkMode;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  page_guard_a: assert property (bankWe || bankRe |-> bankAddr[6:0] != PAGE_CTRL_INDEX) // R6
    else $error("page control location accessed");
  missing_zero_a: assert property (st_r.stage2 && !bankHit |=> st_r.rdData == 8'h00) // R14
    else $error("missing register did not read zero");
  fetch_latency_a: assert property (bankRe |=> ##1 (st_r.mainRdValid || st_r.altRdValid)) // R13
    else $error("bank answer not delivered");
  alt_irq_a: assert property (altAccess && st_r.ctrl[CTRL_ALT_IRQ] |=> interruptRequestOut) // R20
    else $error("alternate access raised no interrupt");
  alt_gate_a: assert property (altEnable |=> !altClockPinFunctionOut && !altClockPinModeOut) // R19
    else $error("clock pin settings active with alternate port");
  alt_off_a: assert property (!altEnable |-> altDataDriveN) // R19
    else $error("disabled alternate port drives data");
endmodule

`default_nettype wire

// ---- verification/two_wire_host_model.sv ----
// host-side bus master model driving one two-wire port
`timescale 1ns/1ps
`default_nettype none
module two_wire_host_model #(
  parameter int HALF = 16
) (
  input wire logic ref_clk,
  input wire logic dataLine,
  output var logic clkLine,
  output var logic dataRel
);
  initial begin
    clkLine = 1'b1;
    dataRel = 1'b1;
  end
  task automatic waitHalf();
    repeat (HALF) @(posedge ref_clk);
  endtask
  // fresh or repeated start; clock stands high between frames
  task automatic startCond();
    dataRel <= 1'b1;
    waitHalf();
    clkLine <= 1'b1;
    waitHalf();
    dataRel <= 1'b0;
    waitHalf();
    clkLine <= 1'b0;
    waitHalf();
  endtask
  task automatic stopCond();
    dataRel <= 1'b0;
    waitHalf();
    clkLine <= 1'b1;
    waitHalf();
    dataRel <= 1'b1;
    waitHalf();
  endtask
  // data moves only with clock low; short hold after the fall
  task automatic bitCycle(input logic v, output logic s);
    dataRel <= v;
    waitHalf();
    clkLine <= 1'b1;
    waitHalf();
    s = dataLine;
    clkLine <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic putByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitCycle(b[i], s);
    bitCycle(1'b1, ack);
  endtask
  task automatic getByte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bitCycle(1'b1, b[i]);
    bitCycle(nack, s);
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the two-wire slave port block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pmic_two_wire_pkg::*;
  logic ref_clk, rst, regWr, regRd, bankWe, bankRe, bankHit, mainDataOut, mainDataDriveN, altDataOut, altDataDriveN;
  logic interruptRequestOut, altWakeupOut, altClockPinFunctionOut, altClockPinModeOut, mClk, mRel, aClk, aRel, ack;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata, bankAddr, bankWdata, bankRdata, rd;
  logic [7:0] mem [256];
  logic [7:0] rstVal [8] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h01, 8'h00, 8'h00, 8'h00};
  int n_mismatch, checks, interrupt_request_out, nWake;
  // open-drain wires with pull-up
  wire logic mLine = mRel & (mainDataDriveN | mainDataOut);
  wire logic aLine = aRel & (altDataDriveN | altDataOut);
  pmic_two_wire_slave_port u_pmic_two_wire_slave_port (.ref_clk, .rst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .serialClockLine(mClk), .mainDataIn(mLine), .mainDataOut, .mainDataDriveN, .altClockLine(aClk),
    .altDataIn(aLine), .altDataOut, .altDataDriveN, .bankAddr, .bankWdata, .bankWe, .bankRe, .bankRdata, .bankHit,
    .interruptRequestOut, .altWakeupOut, .altClockPinFunctionOut, .altClockPinModeOut);
  two_wire_host_model u_two_wire_host_model (.ref_clk, .dataLine(mLine), .clkLine(mClk), .dataRel(mRel));
  two_wire_host_model u_two_wire_host_model_alt (.ref_clk, .dataLine(aLine), .clkLine(aClk), .dataRel(aRel));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // bank model; addresses from 0xf0 up do not exist, answers only a read strobe
  always @(posedge ref_clk) begin
    if (bankWe) mem[bankAddr] <= bankWdata;
    if (bankRe) begin
      bankRdata <= mem[bankAddr];
      bankHit <= bankAddr < 8'hf0;
    end
    if (interruptRequestOut === 1'b1) interrupt_request_out <= interrupt_request_out + 1;
    if (altWakeupOut === 1'b1) nWake <= nWake + 1;
  end
  task automatic end_sim();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic regWrite(input logic [2:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [2:0] a, output logic [7:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
    @(posedge ref_clk);
  endtask
  task automatic put(input logic [7:0] d);
    u_two_wire_host_model.putByte(d, ack);
    check({7'h00, ack}, 8'h00);
  endtask
  task automatic head(input logic [7:0] dev, input logic [7:0] a);
    u_two_wire_host_model.startCond();
    put(dev);
    put(a);
  endtask
  task automatic getOne(input logic nack, input logic [7:0] exp);
    u_two_wire_host_model.getByte(nack, rd);
    check(rd, exp);
  endtask
  // watchdog, far beyond the expected run length
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    {n_mismatch, checks, interrupt_request_out, nWake} = '0;
    {rst, regWr, regRd, regAddr, regWdata} = {1'b1, 13'h0};
    // missing cells and page control cell 0x80 hold junk, so a zero answer means something
    for (int i = 0; i < 256; i++) mem[i] = (i >= 8'hf0 || i == 8'h80) ? 8'hee : 8'h00;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      regRead(3'(i), rd);
      check(rd, rstVal[i]);
    end
    // consecutive write, then consecutive read through a repeated start
    head(8'h90, 8'h12);
    put(8'h5a);
    put(8'ha5);
    u_two_wire_host_model.stopCond();
    check(mem[8'h12], 8'h5a);
    check(mem[8'h13], 8'ha5);
    head(8'h90, 8'h12);
    u_two_wire_host_model.startCond();
    put(8'h91);
    getOne(1'b0, 8'h5a);
    getOne(1'b1, 8'ha5);
    u_two_wire_host_model.stopCond();
    head(8'h90, 8'hf5);
    u_two_wire_host_model.startCond();
    put(8'h91);
    getOne(1'b1, 8'h00);
    u_two_wire_host_model.stopCond();
    // page-control index is skipped, next index written
    head(8'h90, 8'h80);
    put(8'h11);
    put(8'h22);
    u_two_wire_host_model.stopCond();
    check(mem[8'h80], 8'hee);
    check(mem[8'h81], 8'h22);
    head(8'h90, 8'h80);
    u_two_wire_host_model.startCond();
    put(8'h91);
    getOne(1'b0, 8'h00);
    getOne(1'b1, 8'h22);
    u_two_wire_host_model.stopCond();
    // stop in mid data byte drops the message
    head(8'h90, 8'h50);
    repeat (3) u_two_wire_host_model.bitCycle(1'b0, ack);
    u_two_wire_host_model.stopCond();
    check(mem[8'h50], 8'h00);
    u_two_wire_host_model.startCond();
    u_two_wire_host_model.putByte(8'ha0, ack);
    check({7'h00, ack}, 8'h01);
    u_two_wire_host_model.stopCond();
    // alternating address and data
    regWrite(REG_CTRL, 8'h03);
    head(8'h90, 8'h20);
    put(8'h33);
    put(8'h40);
    put(8'h44);
    u_two_wire_host_model.stopCond();
    check(mem[8'h20], 8'h33);
    check(mem[8'h40], 8'h44);
    // alternate port with interrupt and wake-up; clock pin settings masked
    regWrite(REG_CTRL, 8'h7d);
    u_two_wire_host_model_alt.startCond();
    u_two_wire_host_model_alt.putByte(8'h92, ack);
    check({7'h00, ack}, 8'h00);
    u_two_wire_host_model_alt.putByte(8'h60, ack);
    u_two_wire_host_model_alt.putByte(8'h77, ack);
    u_two_wire_host_model_alt.stopCond();
    check(mem[8'h60], 8'h77);
    check(8'(interrupt_request_out), 8'h01);
    check(8'(nWake), 8'h01);
    check({6'h00, altClockPinFunctionOut, altClockPinModeOut}, 8'h00);
    regWrite(REG_CTRL, 8'h61);
    repeat (2) @(posedge ref_clk);
    check({6'h00, altClockPinFunctionOut, altClockPinModeOut}, 8'h03);
    // a reconfigured write address is answered
    regWrite(REG_MAIN_WR_ADDR, 8'ha0);
    head(8'ha0, 8'h70);
    put(8'h66);
    u_two_wire_host_model.stopCond();
    check(mem[8'h70], 8'h66);
    end_sim();
  end
endmodule
`default_nettype wire
